/* hw/ulsf_top.sv */
`timescale 1ns/1ps
module ulsf_top #(
  parameter int RX_DEPTH = ulsf_pkg::RX_DEPTH,
  parameter int TX_DEPTH = ulsf_pkg::TX_DEPTH,
  parameter int FRAME_BITS = ulsf_pkg::FRAME_BITS
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ulsf_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Receiver events
  input wire logic rx_in,
  input wire logic rx_bit_tick,
  input wire logic rx_done,
  input wire logic rx_parity_err,
  input wire logic rx_frame_err,
  input wire logic rx_pop,
  // Transmitter events
  input wire logic tx_write,
  input wire logic tx_move,
  input wire logic tx_shift_done,
  // Status and interrupts
  output logic [7:0] line_status,
  output logic thre_irq,
  output logic irq
);
  localparam int TW = $clog2(TX_DEPTH) + 1;
  localparam int BW = $clog2(FRAME_BITS) + 1;

  typedef struct packed {
    logic [ulsf_pkg::CTRL_W-1:0] ctrl;
    logic [ulsf_pkg::EV_W-1:0] ev_sts;
    logic [ulsf_pkg::EV_W-1:0] ev_en;
    logic overrun;
    logic [TW-1:0] tx_cnt;
    logic tx_busy;
    logic thre_prev;
    ulsf_pkg::ulsf_brk_type brk;
    logic [BW-1:0] brk_cnt;
    logic [31:0] rdata;
  } ulsf_state_type;

  ulsf_state_type q, d;
  logic fifo_en;
  logic brk_push;
  logic rx_push;
  logic [ulsf_pkg::FL_W-1:0] push_flags;
  logic rxf_empty;
  logic rxf_full;
  logic [ulsf_pkg::FL_W-1:0] top_flags;
  logic rxf_any_err;
  logic tx_full;
  logic thre;
  logic temt;
  logic setup_ph;
  logic access;
  logic mapped;
  logic [ulsf_pkg::EV_W-1:0] ev_set;

  assign fifo_en = q.ctrl[ulsf_pkg::CTRL_FIFO_EN];

  // A break pushes one character with only its break flag set
  assign brk_push = (q.brk == ulsf_pkg::BRK_COUNT) && rx_bit_tick && !rx_in &&
                    (q.brk_cnt == BW'(FRAME_BITS - 1));
  assign rx_push = brk_push || rx_done;
  always_comb begin
    push_flags = '0;
    if (brk_push) begin
      push_flags[ulsf_pkg::FL_BREAK] = 1'b1;
    end else begin
      push_flags[ulsf_pkg::FL_PARITY] = rx_parity_err;
      push_flags[ulsf_pkg::FL_FRAMING] = rx_frame_err;
    end
  end

  // Error flags of held receive characters
  ulsf_err_fifo #(
    .DEPTH(RX_DEPTH)
  ) u_rx_flags (
    .clock(clock),
    .resetn(resetn),
    .push(rx_push),
    .push_flags(push_flags),
    .one_deep(!fifo_en),
    .pop(rx_pop),
    .empty(rxf_empty),
    .full(rxf_full),
    .top_flags(top_flags),
    .any_err(rxf_any_err)
  );

  // Transmit occupancy; non-FIFO mode is a single holding register
  assign tx_full = fifo_en ? (q.tx_cnt == TW'(TX_DEPTH)) : (q.tx_cnt != '0);
  assign thre = (q.tx_cnt == '0);
  assign temt = thre && !q.tx_busy;

  // Status word; top-of-FIFO flags follow the oldest character
  always_comb begin
    line_status = '0;
    line_status[ulsf_pkg::LS_RX_READY] = !rxf_empty;
    line_status[ulsf_pkg::LS_OVERRUN] = q.overrun;
    line_status[ulsf_pkg::LS_PARITY] = !rxf_empty && top_flags[ulsf_pkg::FL_PARITY];
    line_status[ulsf_pkg::LS_FRAMING] = !rxf_empty && top_flags[ulsf_pkg::FL_FRAMING];
    line_status[ulsf_pkg::LS_BREAK] = !rxf_empty && top_flags[ulsf_pkg::FL_BREAK];
    line_status[ulsf_pkg::LS_THR_EMPTY] = thre;
    line_status[ulsf_pkg::LS_TX_EMPTY] = temt;
    line_status[ulsf_pkg::LS_FIFO_ERR] = rxf_any_err;
  end

  // APB decode: zero wait, read data latched in the setup phase
  assign setup_ph = psel && !penable;
  assign access = psel && penable;
  assign mapped = (paddr == ulsf_pkg::ADDR_LINE_STATUS) || (paddr == ulsf_pkg::ADDR_CTRL) ||
                  (paddr == ulsf_pkg::ADDR_INT_STATUS) || (paddr == ulsf_pkg::ADDR_INT_CLEAR) ||
                  (paddr == ulsf_pkg::ADDR_INT_ENABLE);
  assign pready = 1'b1;
  assign pslverr = access && !mapped;
  assign prdata = q.rdata;

  // Interrupt events
  always_comb begin
    ev_set = '0;
    ev_set[ulsf_pkg::EV_OVERRUN] = rx_push && rxf_full;
    ev_set[ulsf_pkg::EV_BREAK] = brk_push;
    ev_set[ulsf_pkg::EV_RX_ERR] = rx_push && !rxf_full && (|push_flags);
    ev_set[ulsf_pkg::EV_THR_EMPTY] = thre && !q.thre_prev;
  end
  assign irq = |(q.ev_sts & q.ev_en);
  assign thre_irq = thre && q.ctrl[ulsf_pkg::CTRL_THRE_IE];

  // Next-state logic for all block state
  always_comb begin
    d = q;
    d.thre_prev = thre;
    // Read data is captured one edge early so prdata comes from a flop
    if (setup_ph && !pwrite) begin
      case (paddr)
        ulsf_pkg::ADDR_LINE_STATUS: d.rdata = {24'h000000, line_status};
        ulsf_pkg::ADDR_CTRL: d.rdata = {30'h00000000, q.ctrl};
        ulsf_pkg::ADDR_INT_STATUS: d.rdata = {28'h0000000, q.ev_sts};
        ulsf_pkg::ADDR_INT_ENABLE: d.rdata = {28'h0000000, q.ev_en};
        default: d.rdata = 32'h00000000;
      endcase
    end
    // Writes; the line status address takes none
    if (access && pwrite) begin
      case (paddr)
        ulsf_pkg::ADDR_CTRL: d.ctrl = pwdata[ulsf_pkg::CTRL_W-1:0];
        ulsf_pkg::ADDR_INT_CLEAR: d.ev_sts = q.ev_sts & ~pwdata[ulsf_pkg::EV_W-1:0];
        ulsf_pkg::ADDR_INT_ENABLE: d.ev_en = pwdata[ulsf_pkg::EV_W-1:0];
        default: d.ctrl = q.ctrl;
      endcase
    end
    // Set wins over a same-cycle clear
    d.ev_sts = d.ev_sts | ev_set;
    // Overrun clears on a status read, but a new overrun wins
    if (access && !pwrite && (paddr == ulsf_pkg::ADDR_LINE_STATUS)) begin
      d.overrun = 1'b0;
    end
    if (rx_push && rxf_full) begin
      d.overrun = 1'b1;
    end
    // Transmit holding and shift occupancy
    d.tx_cnt = q.tx_cnt + TW'(tx_write && !tx_full) - TW'(tx_move && !thre);
    if (tx_move && !thre) begin
      d.tx_busy = 1'b1;
    end else if (tx_shift_done) begin
      d.tx_busy = 1'b0;
    end
    // Break detector counts low bit samples of one frame
    if (rx_bit_tick) begin
      case (q.brk)
        ulsf_pkg::BRK_IDLE: begin
          if (!rx_in) begin
            d.brk = ulsf_pkg::BRK_COUNT;
            d.brk_cnt = BW'(1);
          end
        end
        ulsf_pkg::BRK_COUNT: begin
          if (rx_in) begin
            d.brk = ulsf_pkg::BRK_IDLE;
          end else if (brk_push) begin
            d.brk = ulsf_pkg::BRK_HELD;
          end else begin
            d.brk_cnt = q.brk_cnt + BW'(1);
          end
        end
        ulsf_pkg::BRK_HELD: begin
          // Stays here however long the line is low
          if (rx_in) begin
            d.brk = ulsf_pkg::BRK_IDLE;
          end
        end
        default: d.brk = ulsf_pkg::BRK_IDLE;
      endcase
    end
  end

  // All state in one register; every flag starts clear except thre_prev, which starts set
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
      q.ctrl <= ulsf_pkg::CTRL_RESET;
      q.ev_sts <= ulsf_pkg::EV_RESET;
      q.ev_en <= ulsf_pkg::EV_RESET;
      q.thre_prev <= 1'b1;
      q.brk <= ulsf_pkg::BRK_IDLE;
    end else begin
      q <= d;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  a_err_sum_set: assert property (rx_done && !brk_push && !rxf_full &&
    (rx_parity_err || rx_frame_err) |=> line_status[7]) else $error("error summary not set");
  a_err_sum_hold: assert property (line_status[7] && !rx_pop |=> line_status[7])
    else $error("error summary dropped early");
  a_temt_load: assert property (tx_write && !tx_full |=> !line_status[6])
    else $error("tx empty stayed set on load");
  a_temt_fifo: assert property (line_status[6] |-> line_status[5])
    else $error("tx empty without holding empty");
  a_thre_load: assert property (tx_write && !tx_full && !tx_move |=> !line_status[5])
    else $error("holding empty not cleared on load");
  a_thre_irq: assert property ($rose(line_status[5]) && q.ctrl[1] |-> thre_irq)
    else $error("holding empty irq missing");
  a_thre_move: assert property (tx_move && q.tx_cnt == 1 && !tx_write |=> line_status[5])
    else $error("holding empty not set on drain");
  a_break_set: assert property (brk_push && rxf_empty |=> line_status[4])
    else $error("break flag not set");
  a_break_once: assert property (q.brk == ulsf_pkg::BRK_HELD |-> !brk_push)
    else $error("second break character");
  a_overrun_set: assert property (rx_done && rxf_full |=> line_status[1])
    else $error("overrun not flagged");
  c_break: cover property (brk_push ##1 line_status[4]);
  c_overrun: cover property (rx_done && rxf_full);
  c_irq: cover property ($rose(irq));
endmodule : ulsf_top

/* hw/ulsf_pkg.sv */
package ulsf_pkg;
  // Register byte offsets
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_LINE_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_INT_STATUS = 8'h08;
  localparam logic [7:0] ADDR_INT_CLEAR = 8'h0c;
  localparam logic [7:0] ADDR_INT_ENABLE = 8'h10;
  // Line status bit positions
  localparam int LS_RX_READY = 0;
  localparam int LS_OVERRUN = 1;
  localparam int LS_PARITY = 2;
  localparam int LS_FRAMING = 3;
  localparam int LS_BREAK = 4;
  localparam int LS_THR_EMPTY = 5;
  localparam int LS_TX_EMPTY = 6;
  localparam int LS_FIFO_ERR = 7;
  // Control bits
  localparam int CTRL_W = 2;
  localparam int CTRL_FIFO_EN = 0;
  localparam int CTRL_THRE_IE = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  // Interrupt event bits
  localparam int EV_W = 4;
  localparam int EV_OVERRUN = 0;
  localparam int EV_BREAK = 1;
  localparam int EV_RX_ERR = 2;
  localparam int EV_THR_EMPTY = 3;
  localparam logic [3:0] EV_RESET = 4'h0;
  // Per-character error flag layout
  localparam int FL_W = 3;
  localparam int FL_PARITY = 0;
  localparam int FL_FRAMING = 1;
  localparam int FL_BREAK = 2;
  // Sizes and timing counts
  localparam int RX_DEPTH = 128;
  localparam int TX_DEPTH = 128;
  localparam int FRAME_BITS = 10;
  // Break detector states
  typedef enum logic [1:0] {
    BRK_IDLE = 2'b00,
    BRK_COUNT = 2'b01,
    BRK_HELD = 2'b10
  } ulsf_brk_type;
endpackage : ulsf_pkg

/* hw/ulsf_err_fifo.sv */
`timescale 1ns/1ps
module ulsf_err_fifo #(
  parameter int DEPTH = ulsf_pkg::RX_DEPTH,
  parameter int AW = $clog2(DEPTH)
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Push side
  input wire logic push,
  input wire logic [ulsf_pkg::FL_W-1:0] push_flags,
  input wire logic one_deep,
  // Pop side
  input wire logic pop,
  // Status
  output logic empty,
  output logic full,
  output logic [ulsf_pkg::FL_W-1:0] top_flags,
  output logic any_err
);
  typedef struct packed {
    logic [DEPTH-1:0][ulsf_pkg::FL_W-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } ulsf_fifo_state_type;

  ulsf_fifo_state_type q, d;
  logic [DEPTH-1:0] entry_err;

  // Holding register mode limits occupancy to one character
  assign empty = (q.cnt == '0);
  assign full = one_deep ? !empty : (q.cnt == (AW+1)'(DEPTH));
  assign top_flags = q.mem[q.rd];

  // Error summary over every occupied entry only
  genvar i;
  generate
    for (i = 0; i < DEPTH; i++) begin : g_ent
      logic [AW-1:0] offs;
      assign offs = AW'(i) - q.rd;
      assign entry_err[i] = (|q.mem[i]) && ({1'b0, offs} < q.cnt);
    end
  endgenerate
  assign any_err = |entry_err;

  // Pointer and count update; full push is dropped, contents untouched
  always_comb begin
    d = q;
    if (push && !full) begin
      d.mem[q.wr] = push_flags;
      d.wr = q.wr + AW'(1);
    end
    if (pop && !empty) begin
      d.rd = q.rd + AW'(1);
    end
    d.cnt = q.cnt + (AW+1)'(push && !full) - (AW+1)'(pop && !empty);
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule : ulsf_err_fifo

/* test/ulsf_line_model.sv */
`timescale 1ns/1ps
// Serial line side: idle-high receive line and a free-running bit tick
module ulsf_line_model (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Line control
  input wire logic hold_low,
  output logic rx_in,
  output logic rx_bit_tick
);
  logic [1:0] div_q;
  // Bit time of four clocks keeps break frames short
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      div_q <= 2'h0;
    end else begin
      div_q <= div_q + 2'h1;
    end
  end
  // Line idles high; a break holds it low as long as asked
  assign rx_in = !hold_low;
  assign rx_bit_tick = (div_q == 2'h3);
endmodule : ulsf_line_model

/* test/ulsf_top_tb.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module ulsf_top_tb;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, se;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic rx_in, tick, pe = 1'b0, fe = 1'b0, brk = 1'b0, thre_irq, irq;
  logic [4:0] ev = 5'h00;
  logic [7:0] line_status;
  int mismatches = 0;
  int checked = 0;
  // Half period of 10 ns gives 50 MHz
  always #10 clock = ~clock;
  ulsf_line_model ulsf_line_model_inst (.clock(clock), .resetn(resetn), .hold_low(brk),
    .rx_in(rx_in), .rx_bit_tick(tick));
  // Small depths so a full receive FIFO is reached quickly
  ulsf_top #(.RX_DEPTH(4), .TX_DEPTH(4), .FRAME_BITS(10)) ulsf_top_inst (.clock(clock),
    .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_in(rx_in),
    .rx_bit_tick(tick), .rx_done(ev[0]), .rx_parity_err(pe), .rx_frame_err(fe),
    .rx_pop(ev[1]), .tx_write(ev[2]), .tx_move(ev[3]), .tx_shift_done(ev[4]),
    .line_status(line_status), .thre_irq(thre_irq), .irq(irq));
  task automatic test_done();
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done
  // One APB transfer; waits for pready with a bound so a hang ends the run
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      test_done();
    end
    q = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so a following call never reassigns psel in this time step
    @(posedge clock);
  endtask : apb
  // One-cycle event pulse, then one edge for the flags to land
  task automatic pulse(input int i);
    ev[i] <= 1'b1;
    @(posedge clock);
    ev <= 5'h00;
    @(posedge clock);
  endtask : pulse
  task automatic rx(input logic p, input logic f);
    pe <= p;
    fe <= f;
    pulse(0);
  endtask : rx
  // Sample off the edge, then realign to the next rising edge
  task automatic chk_ls(input logic [7:0] e);
    #1;
    `CHK(line_status, e)
    @(posedge clock);
  endtask : chk_ls
  initial begin
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    apb(1'b0, 8'h00, 32'h0);
    `CHK(q, 32'h60)
    apb(1'b1, 8'h00, 32'hff);
    apb(1'b0, 8'h00, 32'h0);
    `CHK(q, 32'h60)
    apb(1'b0, 8'h40, 32'h0);
    `CHK({se, q}, {1'b1, 32'h0})
    // Single holding register with its interrupt enabled
    apb(1'b1, 8'h04, 32'h2);
    #1 `CHK(thre_irq, 1'b1)
    @(posedge clock);
    pulse(2);
    chk_ls(8'h00);
    `CHK(thre_irq, 1'b0)
    pulse(3);
    chk_ls(8'h20);
    pulse(4);
    chk_ls(8'h60);
    // FIFO mode: holding-empty waits for the last byte to leave
    apb(1'b1, 8'h04, 32'h1);
    pulse(2);
    pulse(2);
    pulse(3);
    chk_ls(8'h00);
    pulse(3);
    chk_ls(8'h20);
    pulse(4);
    chk_ls(8'h60);
    // Error summary follows every held character, per-char flags the top
    apb(1'b1, 8'h0c, 32'hf);
    apb(1'b1, 8'h10, 32'h4);
    rx(1'b0, 1'b0);
    rx(1'b0, 1'b1);
    chk_ls(8'he1);
    `CHK(irq, 1'b1)
    apb(1'b0, 8'h08, 32'h0);
    `CHK(q, 32'h4)
    apb(1'b1, 8'h10, 32'h0);
    #1 `CHK(irq, 1'b0)
    @(posedge clock);
    apb(1'b1, 8'h10, 32'h4);
    apb(1'b1, 8'h0c, 32'h4);
    #1 `CHK(irq, 1'b0)
    @(posedge clock);
    pulse(1);
    chk_ls(8'he9);
    pulse(1);
    chk_ls(8'h60);
    rx(1'b1, 1'b0);
    chk_ls(8'he5);
    pulse(1);
    chk_ls(8'h60);
    // Fifth character into a four-deep FIFO is dropped
    repeat (5) rx(1'b0, 1'b0);
    chk_ls(8'h63);
    apb(1'b0, 8'h00, 32'h0);
    `CHK(q, 32'h63)
    chk_ls(8'h61);
    repeat (4) pulse(1);
    chk_ls(8'h60);
    // Long break: flagged after one frame, one character only
    apb(1'b1, 8'h0c, 32'hf);
    apb(1'b1, 8'h10, 32'h2);
    brk <= 1'b1;
    repeat (30) @(posedge clock);
    chk_ls(8'h60);
    repeat (20) @(posedge clock);
    chk_ls(8'hf1);
    `CHK(irq, 1'b1)
    repeat (100) @(posedge clock);
    brk <= 1'b0;
    repeat (10) @(posedge clock);
    pulse(1);
    chk_ls(8'h60);
    apb(1'b1, 8'h0c, 32'h2);
    #1 `CHK(irq, 1'b0)
    test_done();
  end
endmodule : ulsf_top_tb
